// ---- logic/mser_regbank.sv ----
// Register bank with sequence table engine, application words and action rule engine.
// Assumes an APB master on pclk; motion and application inputs are on pclk too.
//
// Functional notes
// - With repeat set, a zero dwell entry is skipped and the sequence continues.
// - The step pointer holds only 0 to 15, one of sixteen entries.
// - Each finished entry increments the step pointer by one.
// - Goal positions are sixteen signed 32-bit values in 1/4096 revolution.
// - Dwell entries are sixteen unsigned 16-bit values in the selected unit.
// - Load word reports application runtime share, 0 to 100 percent.
// - Revision word: major in upper byte, minor in lower byte.
// - Eight signed 16-bit scratch words for the application.
// - Eight unsigned 16-bit debug words for the application.
// - An event acts on a register when its trigger condition passes its filter, at the times its trigger type selects.
// - Control bits 3..0 select the trigger comparison.
// - Control bits 7..4 select a filter on the trigger condition.
// - Control bits 11..8: 0 while active, 1 on edge, 2 repeatedly.
// - Control bits 15..12 select the data operation of the result.
// - Trigger compares the watched register with the 16-bit watch value.
// - Result combines operand register with 16-bit operand constant.
// - Command word passes to the application; state word comes back.
// - Delay mode 0 times at once; mode 1 times from goal reached.
// - Time scale: 00 milliseconds, bit 2 seconds, bit 3 minutes.
// - Without repeat, a zero dwell entry ends the sequence.
`timescale 1ns/1ps
`default_nettype none
module mser_regbank #(
   parameter int unsigned MS_CYCLES = mser_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Motion control
   input wire logic pos_reached,
   output logic [31:0] goal_position_out,
   output logic seq_active,
   // Custom application
   input wire logic [15:0] app_state_in,
   input wire logic [15:0] app_load_in,
   input wire logic [15:0] app_revision_in,
   output logic [15:0] app_command_out,
   // Action rule results
   output logic evt_fire,
   output logic [2:0] evt_id,
   output logic [15:0] evt_value
);
   import mser_pkg::*;

   localparam int MS_W = $clog2(MS_CYCLES);

   generate
      if (MS_CYCLES < 2) begin : g_bad_ms
         $error("MS_CYCLES must be at least 2");
      end
   endgenerate

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Storage
   logic [31:0] goal_r [16];
   logic [15:0] dwell_r [16];
   logic [15:0] scratch_r [8];
   logic [15:0] debug_r [8];
   logic [15:0] ctrl_r [8];
   logic [15:0] wreg_r [8];
   logic [15:0] wval_r [8];
   logic [15:0] oreg_r [8];
   logic [15:0] ocon_r [8];
   logic [15:0] cfg_r, cmd_r, state_r, load_r, rev_r;
   logic [3:0] ptr_r;

   // One lookup serves the bus and both event operand fetches
   function automatic mser_rd_t reg_read(input logic [13:0] i);
      mser_rd_t r;
      logic [13:0] o;
      r = '0;
      if (i == IDX_SEQ_CFG) r = {2'b10, 16'h0000, cfg_r};
      if (i == IDX_SEQ_PTR) r = {2'b10, 28'h0000000, ptr_r};
      if (i == IDX_CMD) r = {2'b10, 16'h0000, cmd_r};
      if (i == IDX_STATE) r = {2'b11, 16'h0000, state_r};
      if (i == IDX_LOAD) r = {2'b11, 16'h0000, load_r};
      if (i == IDX_REV) r = {2'b11, 16'h0000, rev_r};
      o = i - IDX_GOAL;
      if (o < SEQ_N) r = {2'b10, goal_r[o[3:0]]};
      o = i - IDX_DWELL;
      if (o < SEQ_N) r = {2'b10, 16'h0000, dwell_r[o[3:0]]};
      o = i - IDX_SCRATCH;
      if (o < APP_N) r = {2'b10, 16'h0000, scratch_r[o[2:0]]};
      o = i - IDX_DEBUG;
      if (o < APP_N) r = {2'b10, 16'h0000, debug_r[o[2:0]]};
      o = i - IDX_CTRL;
      if (o < EVT_N) r = {2'b10, 16'h0000, ctrl_r[o[2:0]]};
      o = i - IDX_WREG;
      if (o < EVT_N) r = {2'b10, 16'h0000, wreg_r[o[2:0]]};
      o = i - IDX_WVAL;
      if (o < EVT_N) r = {2'b10, 16'h0000, wval_r[o[2:0]]};
      o = i - IDX_OREG;
      if (o < EVT_N) r = {2'b10, 16'h0000, oreg_r[o[2:0]]};
      o = i - IDX_OCON;
      if (o < EVT_N) r = {2'b10, 16'h0000, ocon_r[o[2:0]]};
      return r;
   endfunction

   // Bus decode
   wire [13:0] idx = paddr[15:2];
   wire [13:0] o_goal = idx - IDX_GOAL;
   wire [13:0] o_dwell = idx - IDX_DWELL;
   wire [13:0] o_scr = idx - IDX_SCRATCH;
   wire [13:0] o_dbg = idx - IDX_DEBUG;
   wire [13:0] o_ctrl = idx - IDX_CTRL;
   wire [13:0] o_wreg = idx - IDX_WREG;
   wire [13:0] o_wval = idx - IDX_WVAL;
   wire [13:0] o_oreg = idx - IDX_OREG;
   wire [13:0] o_ocon = idx - IDX_OCON;
   mser_rd_t bus_rd;
   always_comb bus_rd = reg_read(idx);
   logic pready_r;
   wire acc = psel & penable & pready_r;
   wire wr_ok = acc & pwrite & bus_rd.hit & ~bus_rd.ro;
   wire wr_cfg = wr_ok & (idx == IDX_SEQ_CFG);
   wire wr_ptr = wr_ok & (idx == IDX_SEQ_PTR) & pstrb[0];
   wire wr_cmd = wr_ok & (idx == IDX_CMD);
   wire wr_goal = wr_ok & (o_goal < SEQ_N);
   wire wr_dwell = wr_ok & (o_dwell < SEQ_N);
   wire wr_scr = wr_ok & (o_scr < APP_N);
   wire wr_dbg = wr_ok & (o_dbg < APP_N);
   wire wr_ctrl = wr_ok & (o_ctrl < EVT_N);
   wire wr_wreg = wr_ok & (o_wreg < EVT_N);
   wire wr_wval = wr_ok & (o_wval < EVT_N);
   wire wr_oreg = wr_ok & (o_oreg < EVT_N);
   wire wr_ocon = wr_ok & (o_ocon < EVT_N);
   wire [31:0] wmask_w = mser_merge(32'h0000_0000, 32'hFFFF_FFFF, pstrb);
   wire [15:0] wmask = wmask_w[15:0];

   // Sequence engine signals
   mser_seq_state_t sq_r;
   wire run = cfg_r[CFG_RUN_BIT];
   wire rep = cfg_r[CFG_REPEAT_BIT];
   wire [1:0] scale = cfg_r[CFG_SCALE_LSB +: 2];
   wire dwell_zero = (dwell_r[ptr_r] == 16'h0000);
   wire seq_end = (sq_r == SQ_LOAD) & run & dwell_zero & ~rep;

   // APB answer: zero wait, registered in the setup cycle
   logic [31:0] prdata_r;
   logic pslverr_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata_r <= RST_WORD32;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         pready_r <= 1'b1;
         prdata_r <= (bus_rd.hit && !pwrite) ? bus_rd.val : RST_WORD32;
         pslverr_r <= ~bus_rd.hit | (pwrite & bus_rd.ro);
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end
   assign pready = pready_r;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // Writable tables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 16; k++) begin
            goal_r[k] <= RST_WORD32;
            dwell_r[k] <= RST_WORD16;
         end
         for (int k = 0; k < 8; k++) begin
            scratch_r[k] <= RST_WORD16;
            debug_r[k] <= RST_WORD16;
            ctrl_r[k] <= RST_WORD16;
            wreg_r[k] <= RST_WORD16;
            wval_r[k] <= RST_WORD16;
            oreg_r[k] <= RST_WORD16;
            ocon_r[k] <= RST_WORD16;
         end
      end else begin
         for (int k = 0; k < 16; k++) begin
            if (wr_goal && o_goal[3:0] == 4'(k)) goal_r[k] <= mser_merge(goal_r[k], pwdata, pstrb);
            if (wr_dwell && o_dwell[3:0] == 4'(k)) begin
               dwell_r[k] <= (dwell_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            end
         end
         for (int k = 0; k < 8; k++) begin
            if (wr_scr && o_scr[2:0] == 3'(k)) begin
               scratch_r[k] <= (scratch_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            end
            if (wr_dbg && o_dbg[2:0] == 3'(k)) begin
               debug_r[k] <= (debug_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            end
            if (wr_ctrl && o_ctrl[2:0] == 3'(k)) ctrl_r[k] <= (ctrl_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            if (wr_wreg && o_wreg[2:0] == 3'(k)) wreg_r[k] <= (wreg_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            if (wr_wval && o_wval[2:0] == 3'(k)) wval_r[k] <= (wval_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            if (wr_oreg && o_oreg[2:0] == 3'(k)) oreg_r[k] <= (oreg_r[k] & ~wmask) | (pwdata[15:0] & wmask);
            if (wr_ocon && o_ocon[2:0] == 3'(k)) ocon_r[k] <= (ocon_r[k] & ~wmask) | (pwdata[15:0] & wmask);
         end
      end
   end

   // Configuration, command and application words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= RST_WORD16;
         cmd_r <= RST_WORD16;
         state_r <= RST_WORD16;
         load_r <= RST_WORD16;
         rev_r <= RST_WORD16;
      end else begin
         // Host write wins over the end-of-sequence clear of the run bit
         if (wr_cfg) cfg_r <= (cfg_r & ~wmask) | (pwdata[15:0] & wmask);
         else if (seq_end) cfg_r[CFG_RUN_BIT] <= 1'b0;
         if (wr_cmd) cmd_r <= (cmd_r & ~wmask) | (pwdata[15:0] & wmask);
         state_r <= app_state_in;
         load_r <= (app_load_in > LOAD_MAX) ? LOAD_MAX : app_load_in;
         rev_r <= app_revision_in;
      end
   end
   assign app_command_out = cmd_r;

   // Millisecond prescaler, restarted per entry so the first unit is whole in delay mode 0
   logic [MS_W-1:0] ms_cnt_r;
   wire ms_tick = (ms_cnt_r == MS_W'(MS_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ms_cnt_r <= '0;
      else if (sq_r == SQ_LOAD || ms_tick) ms_cnt_r <= '0;
      else ms_cnt_r <= ms_cnt_r + MS_W'(1);
   end

   // Dwell timer
   logic [16:0] unit_cnt_r;
   logic [15:0] dwell_cnt_r, dwell_tgt_r;
   wire [16:0] unit_len = scale[1] ? UNIT_MIN : (scale[0] ? UNIT_SEC : UNIT_MS);
   wire unit_tick = (sq_r == SQ_DWELL) & ms_tick & (unit_cnt_r == unit_len - 17'h00001);
   wire dwell_done = unit_tick & (dwell_cnt_r == dwell_tgt_r - 16'h0001);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_cnt_r <= '0;
         dwell_cnt_r <= RST_WORD16;
      end else if (sq_r == SQ_LOAD) begin
         unit_cnt_r <= '0;
         dwell_cnt_r <= RST_WORD16;
      end else if (sq_r == SQ_DWELL && ms_tick) begin
         unit_cnt_r <= unit_tick ? 17'h00000 : unit_cnt_r + 17'h00001;
         if (unit_tick) dwell_cnt_r <= dwell_cnt_r + 16'h0001;
      end
   end

   // Sequence state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sq_r <= SQ_IDLE;
         ptr_r <= RST_PTR;
         dwell_tgt_r <= RST_WORD16;
         goal_position_out <= RST_WORD32;
         seq_active <= 1'b0;
      end else begin
         // Host pointer write wins over the automatic advance
         if (wr_ptr) ptr_r <= pwdata[3:0];
         else if (sq_r == SQ_NEXT) ptr_r <= ptr_r + 4'h1;
         seq_active <= run & (sq_r != SQ_IDLE);
         unique case (sq_r)
            SQ_IDLE: if (run) sq_r <= SQ_LOAD;
            SQ_LOAD: begin
               goal_position_out <= goal_r[ptr_r];
               dwell_tgt_r <= dwell_r[ptr_r];
               if (dwell_zero) sq_r <= rep ? SQ_NEXT : SQ_IDLE;
               else sq_r <= cfg_r[CFG_DELAY_BIT] ? SQ_WAIT : SQ_DWELL;
            end
            SQ_WAIT: if (pos_reached) sq_r <= SQ_DWELL;
            SQ_DWELL: if (dwell_done) sq_r <= SQ_NEXT;
            SQ_NEXT: sq_r <= SQ_LOAD;
         endcase
         if (!run) sq_r <= SQ_IDLE;
      end
   end

   // Action rule engine: one rule examined per cycle, round robin
   logic [2:0] ev_r;
   logic [3:0] filt_r [8];
   logic [7:0] prev_r, ms_seen_r;
   mser_evt_ctrl_t ec;
   mser_rd_t watch_rd, src_rd;
   always_comb ec = mser_evt_ctrl_t'(ctrl_r[ev_r]);
   always_comb watch_rd = reg_read(wreg_r[ev_r][13:0]);
   always_comb src_rd = reg_read(oreg_r[ev_r][13:0]);
   wire [15:0] wv = (wreg_r[ev_r][15:14] == 2'b00) ? watch_rd.val[15:0] : RST_WORD16;
   wire [15:0] sv = (oreg_r[ev_r][15:14] == 2'b00) ? src_rd.val[15:0] : RST_WORD16;
   wire [15:0] tv = wval_r[ev_r];
   wire [15:0] cv = ocon_r[ev_r];
   logic cond;
   logic [15:0] result;
   always_comb begin
      unique case (ec.trig_op)
         TOP_EQ: cond = (wv == tv);
         TOP_NE: cond = (wv != tv);
         TOP_GT: cond = (wv > tv);
         TOP_LT: cond = (wv < tv);
         TOP_ANY: cond = |(wv & tv);
         TOP_NONE: cond = ~|(wv & tv);
         default: cond = 1'b0;
      endcase
      unique case (ec.data_op)
         DOP_CONST: result = cv;
         DOP_ADD: result = sv + cv;
         DOP_SUB: result = sv - cv;
         DOP_AND: result = sv & cv;
         DOP_OR: result = sv | cv;
         DOP_XOR: result = sv ^ cv;
         default: result = sv;
      endcase
   end
   // Filter: condition must hold on filter+1 consecutive examinations
   wire accepted = cond & (filt_r[ev_r] >= ec.filter);
   wire fire = (ec.trig_type == TT_ACTIVE) ? accepted :
               (ec.trig_type == TT_EDGE) ? (accepted & ~prev_r[ev_r]) :
               (ec.trig_type == TT_REPEAT) ? (accepted & ms_seen_r[ev_r]) : 1'b0;

   genvar gk;
   generate
      for (gk = 0; gk < 8; gk++) begin : g_evt
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               filt_r[gk] <= 4'h0;
               prev_r[gk] <= 1'b0;
               ms_seen_r[gk] <= 1'b0;
            end else begin
               // A new tick wins over the clear on examination
               if (ms_tick) ms_seen_r[gk] <= 1'b1;
               else if (ev_r == 3'(gk) && accepted) ms_seen_r[gk] <= 1'b0;
               if (ev_r == 3'(gk)) begin
                  prev_r[gk] <= accepted;
                  if (!cond) filt_r[gk] <= 4'h0;
                  else if (filt_r[gk] != 4'hF) filt_r[gk] <= filt_r[gk] + 4'h1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_r <= 3'h0;
         evt_fire <= 1'b0;
         evt_id <= 3'h0;
         evt_value <= RST_WORD16;
      end else begin
         ev_r <= ev_r + 3'h1;
         evt_fire <= fire;
         evt_id <= ev_r;
         evt_value <= result;
      end
   end

   a_ptr_advance: assert property ((sq_r == SQ_NEXT && !wr_ptr) |=> ptr_r == $past(ptr_r) + 4'h1)
      else $error("step pointer did not advance by one");
   a_ptr_wrap: assert property ((sq_r == SQ_NEXT && !wr_ptr && ptr_r == 4'hF) |=> ptr_r == 4'h0)
      else $error("step pointer did not wrap to zero");
   a_zero_end: assert property ((seq_end && !wr_cfg) |=> (sq_r == SQ_IDLE && !run))
      else $error("zero dwell without repeat did not end sequence");
   a_zero_repeat: assert property ((sq_r == SQ_LOAD && run && dwell_zero && rep) |=> sq_r == SQ_NEXT)
      else $error("zero dwell with repeat did not continue");
   a_mode_zero: assert property ((sq_r == SQ_LOAD && run && !dwell_zero && !cfg_r[CFG_DELAY_BIT])
      |=> sq_r == SQ_DWELL || !run)
      else $error("delay mode 0 did not start dwell at once");
   a_mode_one: assert property ((sq_r == SQ_WAIT && run && !pos_reached) |=> sq_r != SQ_DWELL)
      else $error("delay mode 1 timed before goal reached");
   a_goal_load: assert property ((sq_r == SQ_LOAD) |=> goal_position_out == $past(goal_r[ptr_r]))
      else $error("goal output not taken from current entry");
   a_load_range: assert property (load_r <= LOAD_MAX)
      else $error("load word above one hundred");
   a_cmd_write: assert property ((wr_cmd && pstrb[1:0] == 2'b11) |=> app_command_out == $past(pwdata[15:0]))
      else $error("command word not updated by write");
   a_edge_once: assert property (evt_fire |-> ##8 !(evt_fire && $past(ec.trig_type) == TT_EDGE))
      else $error("edge event fired twice");
   a_apb_answer: assert property ((psel && !penable) |=> pready)
      else $error("APB access phase not answered");
endmodule // mser_regbank
`default_nettype wire

// ---- logic/mser_pkg.sv ----
// Constants, types and register map of the motion sequence and event register bank.
// Assumes a 100 MHz pclk and an APB register port with 32-bit data.
`default_nettype none
package mser_pkg;
   // Word indices; byte address is four times the index
   localparam logic [13:0] IDX_SEQ_CFG = 14'h21F4;
   localparam logic [13:0] IDX_SEQ_PTR = 14'h21F5;
   localparam logic [13:0] IDX_GOAL = 14'h21FE;
   localparam logic [13:0] IDX_DWELL = 14'h223A;
   localparam logic [13:0] IDX_CMD = 14'h2258;
   localparam logic [13:0] IDX_STATE = 14'h2259;
   localparam logic [13:0] IDX_LOAD = 14'h225A;
   localparam logic [13:0] IDX_REV = 14'h225B;
   localparam logic [13:0] IDX_SCRATCH = 14'h226C;
   localparam logic [13:0] IDX_DEBUG = 14'h2280;
   localparam logic [13:0] IDX_CTRL = 14'h22A8;
   localparam logic [13:0] IDX_WREG = 14'h22BC;
   localparam logic [13:0] IDX_WVAL = 14'h22D0;
   localparam logic [13:0] IDX_OREG = 14'h22E4;
   localparam logic [13:0] IDX_OCON = 14'h22F8;
   // Table sizes
   localparam logic [13:0] SEQ_N = 14'h0010;
   localparam logic [13:0] APP_N = 14'h0008;
   localparam logic [13:0] EVT_N = 14'h0008;
   // Sequence configuration word fields
   localparam int CFG_DELAY_BIT = 0;
   localparam int CFG_SCALE_LSB = 2;
   localparam int CFG_REPEAT_BIT = 4;
   localparam int CFG_RUN_BIT = 5;
   // Reset values and load word limit
   localparam logic [15:0] RST_WORD16 = 16'h0000;
   localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
   localparam logic [3:0] RST_PTR = 4'h0;
   localparam logic [15:0] LOAD_MAX = 16'h0064;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam logic [16:0] UNIT_MS = 17'h00001;
   localparam logic [16:0] UNIT_SEC = 17'h003E8;
   localparam logic [16:0] UNIT_MIN = 17'h0EA60;

   typedef enum logic [3:0] {TOP_OFF, TOP_EQ, TOP_NE, TOP_GT, TOP_LT, TOP_ANY, TOP_NONE}
      mser_trig_op_t;
   typedef enum logic [3:0] {DOP_SRC, DOP_CONST, DOP_ADD, DOP_SUB, DOP_AND, DOP_OR, DOP_XOR}
      mser_data_op_t;
   typedef enum logic [3:0] {TT_ACTIVE, TT_EDGE, TT_REPEAT} mser_trig_type_t;
   typedef enum logic [2:0] {SQ_IDLE, SQ_LOAD, SQ_WAIT, SQ_DWELL, SQ_NEXT} mser_seq_state_t;

   // Action rule control word, top nibble first
   typedef struct packed {
      logic [3:0] data_op;
      logic [3:0] trig_type;
      logic [3:0] filter;
      logic [3:0] trig_op;
   } mser_evt_ctrl_t;

   // Result of one register lookup
   typedef struct packed {
      logic hit;
      logic ro;
      logic [31:0] val;
   } mser_rd_t;

   function automatic logic [31:0] mser_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ---- testbench/motion_sequence_event_registers_tb.sv ----
// Self-checking bench for the motion sequence and event register bank.
// Assumes mser_pkg is compiled first; the bench drives APB and all side inputs.
`timescale 1ns/1ps
`default_nettype none
module motion_sequence_event_registers_tb;
   import mser_pkg::*;
   typedef struct packed {logic [13:0] idx; logic [31:0] wd; logic [31:0] rd;} mser_row_t;
   typedef struct packed {logic [15:0] ctl; logic [15:0] wv; logic [1:0] cls; logic [15:0] v;}
      mser_evt_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pos_reached, seq_active, evt_fire;
   logic [15:0] paddr, app_state_in, app_load_in, app_revision_in, app_command_out, evt_value;
   logic [15:0] last_val;
   logic [31:0] pwdata, prdata, goal_position_out;
   logic [3:0] pstrb;
   logic [2:0] evt_id, last_id;
   int failures = 0, check_count = 0, fire_n = 0, base, n;
   // Upper halves of 16-bit words must be dropped; pointer keeps bits 3:0
   mser_row_t rows [12] = '{
      '{IDX_CMD, 32'hABCD_1234, 32'h0000_1234}, '{IDX_SCRATCH + 14'd7, 32'hFFFF_8001, 32'h8001},
      '{IDX_DEBUG, 32'h0000_FFFF, 32'hFFFF}, '{IDX_DEBUG + 14'd7, 32'h0000_A5A5, 32'hA5A5},
      '{IDX_CTRL + 14'd7, 32'h0000_0A0A, 32'h0A0A}, '{IDX_WREG + 14'd7, 32'h0001_0007, 32'h7},
      '{IDX_WVAL + 14'd3, 32'h0000_C001, 32'hC001}, '{IDX_OREG + 14'd4, 32'h0000_2259, 32'h2259},
      '{IDX_OCON + 14'd5, 32'h0000_7FFF, 32'h7FFF}, '{IDX_SEQ_PTR, 32'h0000_001F, 32'hF},
      '{IDX_GOAL + 14'd15, 32'h8000_0000, 32'h8000_0000}, '{IDX_DWELL + 14'd15, 32'h1234_FFFF, 32'hFFFF}};
   // cls: 0 no fire, 1 exactly one, 2 three or more in the window
   mser_evt_row_t ev [11] = '{
      '{16'h2001, 16'h0055, 2'd2, 16'h0110}, '{16'h0002, 16'h0055, 2'd0, 16'h0},
      '{16'h00F1, 16'h0055, 2'd0, 16'h0}, '{16'h5003, 16'h0010, 2'd2, 16'h0110},
      '{16'h0004, 16'h0010, 2'd0, 16'h0}, '{16'h3013, 16'h0010, 2'd2, 16'h00F0},
      '{16'h6005, 16'h0001, 2'd2, 16'h0110}, '{16'h4006, 16'h0002, 2'd2, 16'h0000},
      '{16'h1000, 16'h0055, 2'd0, 16'h0}, '{16'h1101, 16'h0055, 2'd1, 16'h0010},
      '{16'h0201, 16'h0055, 2'd2, 16'h0100}};

   mser_regbank #(.MS_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_reached(pos_reached),
      .goal_position_out(goal_position_out), .seq_active(seq_active),
      .app_state_in(app_state_in), .app_load_in(app_load_in), .app_revision_in(app_revision_in),
      .app_command_out(app_command_out), .evt_fire(evt_fire), .evt_id(evt_id),
      .evt_value(evt_value));

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   always @(posedge pclk) begin
      if (evt_fire === 1'b1) begin
         fire_n++;
         last_val = evt_value;
         last_id = evt_id;
      end
   end

   function automatic logic [31:0] gl(input int i);
      return (i == 0) ? 32'h8000_0001 : 32'h1000_0000 + 32'(i);
   endfunction

   task automatic conclude();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Holds the request until pready is sampled high, then one idle edge
   task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd,
                      output logic [31:0] d, output logic er);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) failures++;
      d = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] wd, input logic e);
      logic [31:0] d;
      logic er;
      apb(1'b1, idx, wd, d, er);
      chk($sformatf("wr_err_%h", idx), {31'h0, er}, {31'h0, e});
   endtask

   task automatic rd(input logic [13:0] idx, input logic [31:0] exp, input logic e);
      logic [31:0] d;
      logic er;
      apb(1'b0, idx, 32'h0, d, er);
      chk($sformatf("rd_err_%h", idx), {31'h0, er}, {31'h0, e});
      chk($sformatf("rd_%h", idx), d, exp);
   endtask

   task automatic wait_goal(input logic [31:0] g, input int lim);
      int k;
      k = 0;
      while (goal_position_out !== g && k < lim) begin
         @(posedge pclk);
         k++;
      end
      chk("goal", goal_position_out, g);
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      failures++;
      conclude();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0;
      pwdata = 32'h0; pstrb = 4'hF; pos_reached = 1'b0;
      app_state_in = 16'hBEEF; app_load_in = 16'h00C8; app_revision_in = 16'h0302;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("rst_goal", goal_position_out, RST_WORD32);
      chk("rst_flags", {12'h0, seq_active, evt_fire, pready, pslverr, app_command_out}, 32'h0);
      rd(IDX_SEQ_PTR, 32'h0, 1'b0);
      rd(IDX_GOAL + 14'd5, RST_WORD32, 1'b0);
      rd(IDX_STATE, 32'hBEEF, 1'b0);
      rd(IDX_LOAD, {16'h0, LOAD_MAX}, 1'b0);
      rd(IDX_REV, 32'h0302, 1'b0);
      wr(IDX_REV, 32'h0000_FFFF, 1'b1);
      rd(IDX_REV, 32'h0302, 1'b0);
      rd(14'h0000, 32'h0, 1'b1);
      wr(14'h3FFF, 32'h1, 1'b1);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd, 1'b0);
         rd(rows[i].idx, rows[i].rd, 1'b0);
      end
      chk("cmd_out", {16'h0, app_command_out}, 32'h1234);
      // Rule 0 watches the command word and uses scratch word 0 as operand
      wr(IDX_WREG, {18'h0, IDX_CMD}, 1'b0);
      wr(IDX_OREG, {18'h0, IDX_SCRATCH}, 1'b0);
      wr(IDX_OCON, 32'h0010, 1'b0);
      wr(IDX_CMD, 32'h0055, 1'b0);
      wr(IDX_SCRATCH, 32'h0100, 1'b0);
      foreach (ev[k]) begin
         wr(IDX_CTRL, 32'h0, 1'b0);
         wr(IDX_WVAL, {16'h0, ev[k].wv}, 1'b0);
         repeat (10) @(posedge pclk);
         base = fire_n;
         wr(IDX_CTRL, {16'h0, ev[k].ctl}, 1'b0);
         repeat (40) @(posedge pclk);
         n = fire_n - base;
         chk("evt_count", 32'((n == 0) ? 0 : (n == 1) ? 1 : (n >= 3) ? 2 : 3), 32'(ev[k].cls));
         if (n > 0) begin
            chk("evt_val", {16'h0, last_val}, {16'h0, ev[k].v});
            chk("evt_id", {29'h0, last_id}, 32'h0);
         end
      end
      wr(IDX_CTRL, 32'h0, 1'b0);
      for (int i = 0; i < 16; i++) begin
         wr(IDX_GOAL + 14'(i), gl(i), 1'b0);
         wr(IDX_DWELL + 14'(i), 32'h1, 1'b0);
      end
      // No repeat: entry 15 has zero dwell and ends the run
      wr(IDX_DWELL + 14'd15, 32'h0, 1'b0);
      wr(IDX_SEQ_PTR, 32'd14, 1'b0);
      wr(IDX_SEQ_CFG, 32'h20, 1'b0);
      wait_goal(gl(14), 10);
      chk("active", {31'h0, seq_active}, 32'h1);
      n = 0;
      while (seq_active !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk("ended", {31'h0, seq_active}, 32'h0);
      rd(IDX_SEQ_PTR, 32'd15, 1'b0);
      rd(IDX_SEQ_CFG, 32'h0, 1'b0);
      // Repeat: wraps 15 to 0 and passes the zero dwell of entry 0
      wr(IDX_DWELL + 14'd15, 32'h1, 1'b0);
      wr(IDX_DWELL, 32'h0, 1'b0);
      wr(IDX_SEQ_PTR, 32'd15, 1'b0);
      wr(IDX_SEQ_CFG, 32'h30, 1'b0);
      wait_goal(gl(1), 100);
      chk("rep_active", {31'h0, seq_active}, 32'h1);
      wr(IDX_SEQ_CFG, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk("stopped", {31'h0, seq_active}, 32'h0);
      // Delay mode 1 in ms: a 1 ms dwell must not start before goal reached
      wr(IDX_SEQ_PTR, 32'd2, 1'b0);
      wr(IDX_SEQ_CFG, 32'h21, 1'b0);
      wait_goal(gl(2), 10);
      repeat (40) @(posedge pclk);
      chk("mode1_hold", goal_position_out, gl(2));
      // Switch to seconds while waiting: 1000 ms once goal reached
      wr(IDX_SEQ_CFG, 32'h25, 1'b0);
      pos_reached <= 1'b1;
      repeat (3000) @(posedge pclk);
      chk("sec_hold", goal_position_out, gl(2));
      wait_goal(gl(3), 1500);
      // Minutes: still on entry 3 well past one second
      wr(IDX_SEQ_CFG, 32'h29, 1'b0);
      repeat (5000) @(posedge pclk);
      chk("min_hold", goal_position_out, gl(3));
      wr(IDX_SEQ_CFG, 32'h0, 1'b0);
      pos_reached <= 1'b0;
      conclude();
   end
endmodule // motion_sequence_event_registers_tb
`default_nettype wire
